/* File: hdl/smoke_alarm_sequencer.sv */
// sequencing logic of a photoelectric smoke alarm
`timescale 1ns/1ps
module smoke_alarm_sequencer import smoke_pkg::*; #(
	parameter int TICK_CYCLES = TICK_CYC,
	parameter int EMIT_CYCLES = EMIT_CYC
) (
	input wire logic clk_i, // 125 MHz clock
	input wire logic resetn_i, // async reset, active low
	input wire logic test_i, // test pin
	input wire logic diag_i, // diagnostic entry strobe
	input wire logic smoke_cmp_i, // smoke comparator result
	input wire logic batt_low_i, // battery comparator, high = low
	input wire logic ext_ref_present_i, // external reference wired
	input wire logic io_i, // interconnect line level
	output logic io_o, // interconnect drive level
	output logic io_oe_o, // interconnect drive enable
	output logic io_discharge_o, // interconnect pull-down enable
	output logic strobe_o, // detection supply enable
	output logic emitter_pulse_o, // emitter drive
	output logic high_gain_select_o, // high gain select
	output logic normal_gain_select_o, // normal gain select
	output logic hysteresis_o, // normal gain boost
	output logic ext_ref_select_o, // external smoke reference
	output logic horn_true_out_o, // horn drive
	output logic horn_inverted_out_o, // inverted horn, diag flag
	output logic led_o, // LED drive
	input wire logic [3:0] address_i, // Avalon byte address
	input wire logic read_i, // Avalon read
	input wire logic write_i, // Avalon write
	input wire logic [31:0] writedata_i, // Avalon write data
	output logic [31:0] readdata_o, // Avalon read data
	output logic waitrequest_o // Avalon wait request
);

	localparam int TCW = $clog2(TICK_CYCLES);

	if (TICK_CYCLES < 2 || EMIT_CYCLES < 1 ||
			EMIT_CYCLES >= TICK_CYCLES) begin : g_bad
		$error("tick or emitter length out of range");
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	// ****************************************
	// input synchronisers
	// ****************************************
	logic [5:0] raw;
	logic [5:0] s1_q;
	logic [5:0] s2_q;
	logic test_s, diag_s, smoke_s, batt_s, ext_s, io_s;

	assign raw = {io_i, ext_ref_present_i, batt_low_i, smoke_cmp_i,
		diag_i, test_i};

	for (genvar i = 0; i < 6; i++) begin : g_sync
		always_ff @(posedge clk_i or negedge resetn_i) begin
			if (!resetn_i) begin
				s1_q[i] <= 1'b0;
				s2_q[i] <= 1'b0;
			end else begin
				s1_q[i] <= raw[i];
				s2_q[i] <= s1_q[i];
			end
		end
	end

	assign test_s = s2_q[0];
	assign diag_s = s2_q[1];
	assign smoke_s = s2_q[2];
	assign batt_s = s2_q[3];
	assign ext_s = s2_q[4];
	assign io_s = s2_q[5];

	// ****************************************
	// tick divider
	// ****************************************
	logic [TCW-1:0] tc_q;
	logic tick_en;
	logic emit_win;

	assign tick_en = tc_q == TCW'(TICK_CYCLES - 1);
	assign emit_win = tc_q >= TCW'(TICK_CYCLES - EMIT_CYCLES);

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tc_q <= '0;
		end else if (tick_en) begin
			tc_q <= '0;
		end else begin
			tc_q <= tc_q + TCW'(1);
		end
	end

	a_tick_wrap: assert property (tick_en |=> tc_q == '0 ##1 !tick_en)
		else $error("tick divider did not wrap");

	// ****************************************
	// state registers
	// ****************************************
	logic det_q, local_q, remote_q, ptest_q, test_t_q, lprev_q;
	logic lowbat_q, cf1_q, cham_fail_q, cham_st_q, timer_q;
	logic diag_q, inhibit_q, wait_q;
	logic [1:0] smoke_cnt_q, clr_q, smk_nx;
	logic [TW-1:0] per_q, gap, iof_q, bt_q, ledc_q, led_per;
	logic [TW-1:0] tmr_q, dmp_q, hc_q;
	logic alarm, det_end, cham_now, chirp_d, horn_alm;
	status_t stat;
	pins_t out_d, out_q;

	assign alarm = local_q | remote_q;
	assign det_end = tick_en & det_q;
	assign cham_now = (bt_q == TW'(CHAMB_T)) & !alarm & !det_q;

	// ****************************************
	// smoke sampling schedule
	// ****************************************
	always_comb begin
		smk_nx = smoke_cnt_q;
		if (det_end) begin
			if (!smoke_s) begin
				smk_nx = 2'h0;
			end else if (smoke_cnt_q != 2'h3) begin
				smk_nx = smoke_cnt_q + 2'h1;
			end
		end
		if (test_t_q || ptest_q) begin
			gap = TW'(PT_T);
		end else if (local_q || smk_nx >= 2'h2) begin
			gap = TW'(SMOKE2_T);
		end else if (smk_nx == 2'h1) begin
			gap = TW'(SMOKE1_T);
		end else begin
			gap = TW'(SAMPLE_T);
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			det_q <= 1'b0;
			per_q <= TW'(SAMPLE_T - 1);
			cham_st_q <= 1'b0;
			test_t_q <= 1'b0;
		end else if (tick_en) begin
			test_t_q <= test_s;
			if (det_q) begin
				det_q <= 1'b0;
				// detection tick itself is part of the gap
				per_q <= gap - TW'(2);
				cham_st_q <= smoke_s;
			end else if (per_q == '0) begin
				det_q <= 1'b1;
			end else if (test_s && per_q >= TW'(PT_T)) begin
				per_q <= TW'(PT_T - 1);
			end else begin
				per_q <= per_q - TW'(1);
			end
		end
	end

	// ****************************************
	// hit counting, local alarm, push test
	// ****************************************
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			smoke_cnt_q <= 2'h0;
			local_q <= 1'b0;
		end else if (det_end) begin
			smoke_cnt_q <= smk_nx;
			if (smk_nx == 2'h3) begin
				local_q <= 1'b1;
			end else if (!smoke_s) begin
				local_q <= 1'b0;
			end
		end
	end

	sequence s_third_hit;
		det_end && smoke_s && smoke_cnt_q == 2'h2;
	endsequence
	a_three_hits: assert property (s_third_hit |=> local_q)
		else $error("third smoke hit did not raise local alarm");

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ptest_q <= 1'b0;
			clr_q <= 2'h0;
		end else if (tick_en && test_s) begin
			ptest_q <= 1'b1;
			clr_q <= 2'h0;
		end else if (det_end && ptest_q && !test_t_q) begin
			if (smoke_s) begin
				clr_q <= 2'h0;
			end else if (clr_q == 2'h2) begin
				ptest_q <= 1'b0;
			end else begin
				clr_q <= clr_q + 2'h1;
			end
		end
	end

	// ****************************************
	// interconnect filter and discharge
	// ****************************************
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			iof_q <= '0;
			remote_q <= 1'b0;
		end else if (local_q || !io_s) begin
			iof_q <= '0;
			remote_q <= 1'b0;
		end else if (tick_en) begin
			if (iof_q == TW'(IOFILT_T)) begin
				remote_q <= 1'b1;
			end else begin
				iof_q <= iof_q + TW'(1);
			end
		end
	end

	a_io_ignored: assert property (local_q |=> !remote_q)
		else $error("interconnect taken as input in local alarm");
	a_io_filter: assert property ($rose(remote_q) |->
		$past(iof_q) == TW'(IOFILT_T) && $past(io_s))
		else $error("remote alarm without full filter time");

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			lprev_q <= 1'b0;
			dmp_q <= '0;
		end else begin
			lprev_q <= local_q;
			if (lprev_q && !local_q) begin
				dmp_q <= TW'(DUMP_T);
			end else if (tick_en && dmp_q != '0) begin
				dmp_q <= dmp_q - TW'(1);
			end
		end
	end

	sequence s_local_end;
		lprev_q && !local_q;
	endsequence
	a_dump_start: assert property (s_local_end |=> ##1
		io_discharge_o [*8])
		else $error("discharge did not follow end of local alarm");

	// ****************************************
	// 43 s cycle, battery and chamber tests
	// ****************************************
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bt_q <= '0;
		end else if (tick_en) begin
			if (bt_q == TW'(CYC43_T - 1)) begin
				bt_q <= '0;
			end else begin
				bt_q <= bt_q + TW'(1);
			end
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			lowbat_q <= 1'b0;
		end else if (tick_en && bt_q == '0 && !alarm) begin
			lowbat_q <= batt_s;
		end
	end

	a_batt_latch: assert property (tick_en && bt_q == '0 && !alarm
		|=> lowbat_q == $past(batt_s))
		else $error("battery state not latched at LED end");

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cf1_q <= 1'b0;
			cham_fail_q <= 1'b0;
		end else if (tick_en && cham_now) begin
			if (smoke_s) begin
				cf1_q <= 1'b0;
				cham_fail_q <= 1'b0;
			end else begin
				cf1_q <= 1'b1;
				cham_fail_q <= cf1_q;
			end
		end
	end

	assign chirp_d = !alarm && !diag_q &&
		((lowbat_q && bt_q == TW'(CYC43_T - 1)) ||
		(cham_fail_q && bt_q == TW'(CHAMB_T + 1)));

	// ****************************************
	// horn temporal pattern
	// ****************************************
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hc_q <= '0;
		end else if (!alarm) begin
			hc_q <= '0;
		end else if (tick_en) begin
			if (hc_q == TW'(HORN_ON_T + HORN_OFF_T - 1)) begin
				hc_q <= '0;
			end else begin
				hc_q <= hc_q + TW'(1);
			end
		end
	end

	// off phase first, so remote horn lands after filter plus off time
	assign horn_alm = alarm && hc_q >= TW'(HORN_OFF_T);

	a_horn_gap: assert property (alarm && !diag_q &&
		hc_q < TW'(HORN_OFF_T) |=> !horn_true_out_o)
		else $error("horn sounds in alarm off phase");

	// ****************************************
	// LED, timer mode, diagnostic mode
	// ****************************************
	assign led_per = (local_q || ptest_q) ? TW'(LED_ALM_T) :
		TW'(LED_TMR_T);

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ledc_q <= '0;
		end else if (tick_en) begin
			if (ledc_q >= led_per - TW'(1)) begin
				ledc_q <= '0;
			end else begin
				ledc_q <= ledc_q + TW'(1);
			end
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			timer_q <= 1'b0;
			tmr_q <= '0;
		end else if (tick_en && test_t_q && !test_s && !inhibit_q &&
				ext_s && !alarm) begin
			timer_q <= 1'b1;
			tmr_q <= '0;
		end else if (tick_en && timer_q) begin
			if (tmr_q == TW'(TIMER_T - 1)) begin
				timer_q <= 1'b0;
			end else begin
				tmr_q <= tmr_q + TW'(1);
			end
		end
	end

	a_timer_ref: assert property ($rose(timer_q) |->
		$past(ext_s) && !$past(inhibit_q))
		else $error("timer mode began without external reference");

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			diag_q <= 1'b0;
		end else if (diag_s) begin
			diag_q <= 1'b1;
		end
	end

	// ****************************************
	// output pins
	// ****************************************
	always_comb begin
		out_d = PINS_RST;
		out_d.strobe = diag_q | det_q | cham_now;
		out_d.emit = out_d.strobe & emit_win;
		out_d.hi_gain = (det_q & test_t_q) | (cham_now & ~det_q) |
			(diag_q & io_s & ext_s);
		out_d.nrm_gain = (det_q & ~test_t_q) |
			(diag_q & io_s & ~ext_s);
		out_d.hyst = local_q;
		out_d.ext_ref = timer_q;
		out_d.io_drv = local_q & ~diag_q;
		out_d.io_dump = (dmp_q != '0) | (lprev_q & ~local_q);
		if (diag_q) begin
			out_d.horn_i = local_q;
			out_d.led = batt_s;
		end else begin
			out_d.horn_t = horn_alm | chirp_d;
			out_d.horn_i = ~(horn_alm | chirp_d);
			if (remote_q && !local_q) begin
				out_d.led = 1'b0;
			end else if (local_q || ptest_q || timer_q) begin
				out_d.led = ledc_q == '0;
			end else begin
				out_d.led = bt_q == '0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			out_q <= PINS_RST;
		end else begin
			out_q <= out_d;
		end
	end

	assign strobe_o = out_q.strobe;
	assign emitter_pulse_o = out_q.emit;
	assign high_gain_select_o = out_q.hi_gain;
	assign normal_gain_select_o = out_q.nrm_gain;
	assign hysteresis_o = out_q.hyst;
	assign ext_ref_select_o = out_q.ext_ref;
	assign horn_true_out_o = out_q.horn_t;
	assign horn_inverted_out_o = out_q.horn_i;
	assign led_o = out_q.led;
	assign io_o = out_q.io_drv;
	assign io_oe_o = out_q.io_drv;
	assign io_discharge_o = out_q.io_dump;

	a_emit_strobe: assert property (emitter_pulse_o |-> strobe_o)
		else $error("emitter pulsed outside strobe");
	a_hyst_follow: assert property (##1 hysteresis_o ==
		$past(local_q))
		else $error("hysteresis does not follow local alarm");
	a_ptest_gain: assert property (det_q && test_t_q && !diag_q
		|=> high_gain_select_o && !normal_gain_select_o)
		else $error("push test sample not in high gain");
	a_led_remote: assert property (remote_q && !local_q && !diag_q
		|=> !led_o)
		else $error("LED lit during remote only alarm");
	a_diag_pins: assert property (diag_q |=> strobe_o && !io_oe_o)
		else $error("diagnostic mode pin behaviour wrong");
	a_io_drive: assert property (local_q && !diag_q |=> io_oe_o && io_o)
		else $error("local alarm does not drive interconnect");

	// ****************************************
	// Avalon-MM register slave
	// ****************************************
	assign stat = '{local_alarm: local_q, remote_alarm: remote_q,
		push_test: ptest_q, timer_mode: timer_q, diag_mode: diag_q,
		low_batt: lowbat_q, cham_fail: cham_fail_q,
		cham_status: cham_st_q, smoke_hits: smoke_cnt_q};

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= !((read_i || write_i) && wait_q);
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			inhibit_q <= CTRL_INH_RST;
		end else if (write_i && !wait_q && address_i == CTRL_OFS) begin
			inhibit_q <= writedata_i[CTRL_INH_BIT];
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			readdata_o <= '0;
		end else if (read_i && wait_q) begin
			case (address_i)
				CTRL_OFS: readdata_o <= {31'h0, inhibit_q};
				STAT_OFS: readdata_o <= 32'(stat);
				default: readdata_o <= '0;
			endcase
		end
	end

	assign waitrequest_o = wait_q;

endmodule

/* File: common/smoke_pkg.sv */
// constants and types for the smoke alarm sequencer
// Contract
// - all timing derives from 10 ms tick; emitter width is 100 us of clock cycles
// - sample every 11 s, emitter ends tick
// - latch comparator at tick end; smoke shortens
// - three smoke hits enter local alarm
// - battery latched each 43 s, LED end
// - 43 s high-gain chamber test, two fails
// - low battery chirps 10 ms every 43 s
// - alarms skip tests and mute chirps
// - battery chirp before LED, chamber +21 s
// - hysteresis gain boost during local alarm
// - test high: high gain, 330 ms sampling
// - test low: normal gain, three clears exit
// - standby LED 10 ms every 43 s
// - alarm LED every 0.5 s, remote dark
// - timer mode LED every 10 s
// - local alarm drives line, ignores input
// - line discharge 1 s after local alarm
// - remote high line gives remote alarm horn
// - 670 ms filter on interconnect input
// - test falling edge starts 10 min timer
// - no timer without external reference
// - diagnostic mode redefines strobe, emitter, pins
// - alarm horn on about 252 ms
// - alarm horn off about 84 ms
// - remote horn 0.75 to 1.65 s late
package smoke_pkg;

	localparam int CLK_HZ = 125_000_000;
	localparam int TICK_MS = 10;
	localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
	localparam int EMIT_US = 100;
	localparam int EMIT_CYC = CLK_HZ / 1_000_000 * EMIT_US;

	localparam int TW = 16;
	localparam int SAMPLE_MS = 11000;
	localparam int SAMPLE_T = SAMPLE_MS / TICK_MS;
	localparam int SMOKE1_MS = 2700;
	localparam int SMOKE1_T = SMOKE1_MS / TICK_MS;
	localparam int SMOKE2_MS = 1330;
	localparam int SMOKE2_T = SMOKE2_MS / TICK_MS;
	localparam int PT_MS = 330;
	localparam int PT_T = PT_MS / TICK_MS;
	localparam int CYC43_MS = 43000;
	localparam int CYC43_T = CYC43_MS / TICK_MS;
	localparam int CHAMB_MS = 21000;
	localparam int CHAMB_T = CHAMB_MS / TICK_MS;
	localparam int LED_ALM_MS = 500;
	localparam int LED_ALM_T = LED_ALM_MS / TICK_MS;
	localparam int LED_TMR_MS = 10000;
	localparam int LED_TMR_T = LED_TMR_MS / TICK_MS;
	localparam int DUMP_MS = 1000;
	localparam int DUMP_T = DUMP_MS / TICK_MS;
	localparam int IOFILT_MS = 670;
	localparam int IOFILT_T = IOFILT_MS / TICK_MS;
	localparam int HORN_ON_MS = 252;
	localparam int HORN_ON_T = HORN_ON_MS / TICK_MS;
	localparam int HORN_OFF_MS = 84;
	localparam int HORN_OFF_T = HORN_OFF_MS / TICK_MS;
	localparam int TIMER_MS = 600_000;
	localparam int TIMER_T = TIMER_MS / TICK_MS;

	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] STAT_OFS = 4'h4;
	localparam int CTRL_INH_BIT = 0;
	localparam logic CTRL_INH_RST = 1'b0;

	typedef struct packed {
		logic local_alarm;
		logic remote_alarm;
		logic push_test;
		logic timer_mode;
		logic diag_mode;
		logic low_batt;
		logic cham_fail;
		logic cham_status;
		logic [1:0] smoke_hits;
	} status_t;

	typedef struct packed {
		logic strobe;
		logic emit;
		logic hi_gain;
		logic nrm_gain;
		logic hyst;
		logic ext_ref;
		logic horn_t;
		logic horn_i;
		logic led;
		logic io_drv;
		logic io_dump;
	} pins_t;

	localparam pins_t PINS_RST = '0;

endpackage

/* File: testbench/remote_alarm_unit.sv */
// model of another alarm unit sharing the interconnect wire
`timescale 1ns/1ps
module remote_alarm_unit (
	input wire logic alarm_i, // this unit signals alarm
	input wire logic dev_oe_i, // device drives the wire
	input wire logic dev_lvl_i, // level the device drives
	output logic line_o // resolved wire level
);
	// ****************************************
	// wire resolution, internal pull-down
	// ****************************************
	always_comb begin
		if (dev_oe_i) begin
			line_o = dev_lvl_i;
		end else if (alarm_i) begin
			line_o = 1'b1;
		end else begin
			line_o = 1'b0;
		end
	end
endmodule

/* File: testbench/smoke_alarm_sequencer_tb_top.sv */
// self-checking bench for the smoke alarm sequencer
`timescale 1ns/1ps
module smoke_alarm_sequencer_tb_top;
	localparam int TK = 20;
	logic clk_i, resetn_i, test_i, diag_i, smoke_cmp_i, batt_low_i;
	logic ext_ref_present_i, io_i, remote_on, read_i, write_i;
	logic [3:0] address_i;
	logic [31:0] writedata_i, readdata_o, rd;
	logic io_o, io_oe_o, io_discharge_o, strobe_o, emitter_pulse_o;
	logic high_gain_select_o, normal_gain_select_o, hysteresis_o;
	logic ext_ref_select_o, horn_true_out_o, horn_inverted_out_o, led_o;
	logic waitrequest_o;
	int num_errors, samples_checked, cycles, n, m;

	smoke_alarm_sequencer #(.TICK_CYCLES(TK), .EMIT_CYCLES(4))
	u_smoke_alarm_sequencer (.clk_i(clk_i), .resetn_i(resetn_i),
		.test_i(test_i), .diag_i(diag_i), .smoke_cmp_i(smoke_cmp_i),
		.batt_low_i(batt_low_i), .ext_ref_present_i(ext_ref_present_i),
		.io_i(io_i), .io_o(io_o), .io_oe_o(io_oe_o),
		.io_discharge_o(io_discharge_o), .strobe_o(strobe_o),
		.emitter_pulse_o(emitter_pulse_o),
		.high_gain_select_o(high_gain_select_o),
		.normal_gain_select_o(normal_gain_select_o),
		.hysteresis_o(hysteresis_o), .ext_ref_select_o(ext_ref_select_o),
		.horn_true_out_o(horn_true_out_o),
		.horn_inverted_out_o(horn_inverted_out_o), .led_o(led_o),
		.address_i(address_i), .read_i(read_i), .write_i(write_i),
		.writedata_i(writedata_i), .readdata_o(readdata_o),
		.waitrequest_o(waitrequest_o));

	remote_alarm_unit u_remote_alarm_unit (.alarm_i(remote_on),
		.dev_oe_i(io_oe_o), .dev_lvl_i(io_o), .line_o(io_i));

	// ****************************************
	// clock, timeout, helpers
	// ****************************************
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 50000) begin
			num_errors++;
			results();
		end
	end

	task results;
		if (num_errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	function automatic logic pin(input int k);
		case (k)
			0: return strobe_o;
			1: return led_o;
			2: return horn_true_out_o;
			3: return io_oe_o;
			4: return io_discharge_o;
			default: return ext_ref_select_o;
		endcase
	endfunction

	// cycles until the selected output shows level v, at most lim
	task wait_lvl(input int k, input logic v, input int lim, output int cnt);
		cnt = 0;
		while (pin(k) !== v && cnt < lim) begin
			@(posedge clk_i);
			cnt++;
		end
	endtask

	task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
		address_i <= a;
		writedata_i <= wd;
		write_i <= wr;
		read_i <= ~wr;
		do begin
			@(posedge clk_i);
		end while (waitrequest_o !== 1'b0);
		rd = readdata_o;
		write_i <= 1'b0;
		read_i <= 1'b0;
		@(posedge clk_i);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task do_reset;
		resetn_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		resetn_i <= 1'b1;
		@(posedge clk_i);
		chk("pins_rst", {waitrequest_o, strobe_o, led_o, horn_true_out_o,
			io_oe_o, io_discharge_o, ext_ref_select_o}, 32'h40);
		bus(1'b0, 4'h4, 32'h0);
		chk("status_rst", rd, 32'h0);
	endtask

	task t_regs;
		bus(1'b1, 4'h0, 32'h1);
		bus(1'b0, 4'h0, 32'h0);
		chk("inhibit_set", rd[0], 1'b1);
		bus(1'b1, 4'h0, 32'h0);
		bus(1'b0, 4'h0, 32'h0);
		chk("inhibit_clr", rd[0], 1'b0);
		bus(1'b0, 4'hC, 32'h0);
		chk("unmapped", rd, 32'h0);
	endtask

	task t_push;
		test_i <= 1'b1;
		smoke_cmp_i <= 1'b1;
		wait_lvl(0, 1'b1, 1000, n);
		chk("hi_gain", {high_gain_select_o, normal_gain_select_o}, 32'h2);
		m = 0;
		n = 0;
		while (strobe_o === 1'b1 && n < 100) begin
			m = m + (emitter_pulse_o === 1'b1);
			@(posedge clk_i);
			n++;
		end
		chk("strobe_len", n, TK);
		chk("emit_len", m, 4);
		wait_lvl(0, 1'b1, 1000, m);
		chk("push_period", n + m, 33 * TK);
		wait_lvl(3, 1'b1, 4000, n);
		chk("io_drive", {io_o, io_oe_o}, 32'h3);
		@(posedge clk_i);
		chk("hyst", hysteresis_o, 1'b1);
		bus(1'b0, 4'h4, 32'h0);
		chk("local_st", rd[9:8], 32'h2);
		wait_lvl(2, 1'b1, 400, n);
		wait_lvl(2, 1'b0, 1000, n);
		chk("horn_on", n, 25 * TK);
		wait_lvl(2, 1'b1, 400, n);
		chk("horn_off", n, 8 * TK);
		wait_lvl(1, 1'b1, 1200, n);
		wait_lvl(1, 1'b0, 100, n);
		wait_lvl(1, 1'b1, 1200, m);
		chk("led_alarm", n + m, 50 * TK);
		test_i <= 1'b0;
		smoke_cmp_i <= 1'b0;
		wait_lvl(4, 1'b1, 3000, n);
		wait_lvl(4, 1'b0, 3000, n);
		chk("dump_len", n, 100 * TK);
		chk("oe_off", io_oe_o, 1'b0);
		wait_lvl(0, 1'b0, 1000, n);
		wait_lvl(0, 1'b1, 1000, n);
		chk("nrm_gain", {high_gain_select_o, normal_gain_select_o}, 32'h1);
		repeat (110 * TK) @(posedge clk_i);
		chk("no_timer", ext_ref_select_o, 1'b0);
	endtask

	task t_remote;
		remote_on <= 1'b1;
		repeat (40 * TK) @(posedge clk_i);
		remote_on <= 1'b0;
		wait_lvl(2, 1'b1, 100 * TK, n);
		chk("pulse_filtered", n, 100 * TK);
		remote_on <= 1'b1;
		wait_lvl(2, 1'b1, 200 * TK, n);
		chk("remote_delay", n >= 75 * TK && n <= 165 * TK, 1'b1);
		bus(1'b0, 4'h4, 32'h0);
		chk("remote_st", rd[9:8], 32'h1);
		wait_lvl(1, 1'b1, 60 * TK, n);
		chk("remote_led", n, 60 * TK);
		remote_on <= 1'b0;
	endtask

	task t_timer;
		ext_ref_present_i <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			bus(1'b1, 4'h0, {31'h0, ~k[0]});
			test_i <= 1'b1;
			repeat (3 * TK) @(posedge clk_i);
			test_i <= 1'b0;
			wait_lvl(5, 1'b1, 10 * TK, n);
			chk("timer_sel", ext_ref_select_o, k[0]);
			repeat (110 * TK) @(posedge clk_i);
		end
		bus(1'b0, 4'h4, 32'h0);
		chk("timer_st", rd[6], 1'b1);
	endtask

	task t_diag;
		diag_i <= 1'b1;
		batt_low_i <= 1'b1;
		@(posedge clk_i);
		diag_i <= 1'b0;
		repeat (3 * TK) @(posedge clk_i);
		wait_lvl(0, 1'b0, 3 * TK, n);
		chk("strobe_cont", n, 3 * TK);
		chk("diag_pins", {led_o, io_oe_o, horn_inverted_out_o}, 32'h4);
		m = 0;
		repeat (3 * TK) begin
			m = m + (emitter_pulse_o === 1'b1);
			@(posedge clk_i);
		end
		chk("diag_emit", m, 12);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		resetn_i = 1'b0;
		test_i = 1'b0;
		diag_i = 1'b0;
		smoke_cmp_i = 1'b0;
		batt_low_i = 1'b0;
		ext_ref_present_i = 1'b0;
		remote_on = 1'b0;
		read_i = 1'b0;
		write_i = 1'b0;
		address_i = 4'h0;
		writedata_i = 32'h0;
		num_errors = 0;
		samples_checked = 0;
		cycles = 0;
		do_reset();
		t_regs();
		t_push();
		t_remote();
		do_reset();
		t_timer();
		do_reset();
		t_diag();
		results();
	end
endmodule
